// ### logic/mdr_regs.svh
// Purpose: register offsets, fields, reset values and keys for the host register slice
// Assumes: 8-bit register addresses, 16-bit register data
// Notes: definitions only
`ifndef MDR_REGS_SVH
`define MDR_REGS_SVH

// ==========================================================================
// offsets
`define MDR_OFS_ANALOG_SPEED   8'h07
`define MDR_OFS_PART_IDENTITY  8'h08
`define MDR_OFS_UNUSED_FIRST   8'h09
`define MDR_OFS_UNUSED_LAST    8'h2f
`define MDR_OFS_SPEED_COMMAND  8'h30
`define MDR_OFS_UNLOCK_KEY     8'h31
`define MDR_OFS_NVM_READY      8'h32

// ==========================================================================
// fields
`define MDR_ANALOG_MSB         9
`define MDR_DIE_ID_MSB         15
`define MDR_DIE_ID_LSB         8
`define MDR_REV_MSB            7
`define MDR_TAKEOVER_BIT       15
`define MDR_SPEED_MSB          8
`define MDR_NVM_READY_BIT      0

// ==========================================================================
// reset values and keys
`define MDR_SPEED_CMD_RST      16'h0000
`define MDR_UNLOCK_KEY_RST     16'h0000
`define MDR_CUSTOMER_KEY       16'hc0de
`define MDR_CUST_NVM_FIRST     8'h90
`define MDR_CUST_NVM_LAST      8'h96

`endif

// ### logic/mdr_pkg.sv
// Purpose: shared types of the host register slice
// Assumes: constants live in mdr_regs.svh
// Notes: none
package mdr_pkg;
  typedef logic [7:0]  mdr_addr_t;
  typedef logic [15:0] mdr_word_t;

  // ========================================================================
  // register access request
  typedef struct packed {
    logic      rd;
    logic      wr;
    mdr_addr_t addr;
    mdr_word_t wdata;
  } mdr_req_s;

  typedef enum logic [1:0] {
    MDR_SRC_ANALOG,
    MDR_SRC_PWM,
    MDR_SRC_HOST
  } mdr_speed_src_e;
endpackage

// ### logic/mdr_speed_select.sv
// Purpose: chooses the motor speed command source
// Assumes: analog and pwm commands already scaled to 9 bits
// Notes: registered output
`include "mdr_regs.svh"
module mdr_speed_select
  import mdr_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  input  wire logic           host_speed_takeover,
  input  wire logic [8:0]     host_speed_value,
  input  wire logic           pwm_mode,
  input  wire logic [8:0]     analog_cmd,
  input  wire logic [8:0]     pwm_cmd,
  output logic [8:0]          motor_speed_cmd,
  output mdr_speed_src_e      speed_src
);
  logic [8:0]     nxt_cmd;
  mdr_speed_src_e nxt_src;

  always_comb begin
    if (host_speed_takeover) begin
      nxt_cmd = host_speed_value;
      nxt_src = MDR_SRC_HOST;
    end else if (pwm_mode) begin
      nxt_cmd = pwm_cmd;
      nxt_src = MDR_SRC_PWM;
    end else begin
      nxt_cmd = analog_cmd;
      nxt_src = MDR_SRC_ANALOG;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      motor_speed_cmd <= 9'h000;
      speed_src       <= MDR_SRC_ANALOG;
    end else begin
      motor_speed_cmd <= nxt_cmd;
      speed_src       <= nxt_src;
    end
  end

  chk_takeover_path: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    host_speed_takeover |=> (motor_speed_cmd == $past(host_speed_value)))
    else $error("host speed not selected under takeover");
endmodule

// ### logic/mdr_host_regs.sv
// Purpose: host-visible register slice of the motor driver
// Assumes: serial host interface already decoded to a register access port
// Notes: reads answer one cycle after the strobe
`include "mdr_regs.svh"

// Contract
// - analog speed code readable, 10 bits
// - identity at 0x08, die id high
// - identity low byte is revision code
// - 0x09 to 0x2f hold nothing
// - speed command at 0x30 resets zero
// - takeover bit selects host speed value
// - 9-bit speed, bits 14:9 read zero
// - 16-bit unlock key at 0x31, reset zero
// - customer key alone opens customer space
// - nvm ready in bit 0 at 0x32
module mdr_host_regs
  import mdr_pkg::*;
#(
  parameter logic [7:0] DIE_IDENTIFIER        = 8'h5a, // arbitrary value
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h03  // arbitrary value
) (
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  input  wire mdr_req_s       reg_req,
  output logic [15:0]         reg_rdata,
  output logic                reg_rvalid,
  input  wire logic [9:0]     analog_speed_code,
  input  wire logic           pwm_mode,
  input  wire logic [8:0]     pwm_cmd,
  input  wire logic           nvm_ready_flag,
  input  wire logic [7:0]     nvm_access_addr,
  output logic                nvm_customer_grant,
  output logic [8:0]          motor_speed_cmd,
  output mdr_speed_src_e      speed_src
);
  logic        takeover_ff;
  logic [8:0]  speed_value_ff;
  logic [15:0] unlock_key_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic [15:0] nxt_rdata;
  logic        key_ok;

  function automatic logic hit(input mdr_addr_t a, input mdr_addr_t ofs);
    return a == ofs;
  endfunction

  // ========================================================================
  // writable registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      takeover_ff    <= 1'b0;
      speed_value_ff <= 9'h000;
    end else if (reg_req.wr && hit(reg_req.addr, `MDR_OFS_SPEED_COMMAND)) begin
      takeover_ff    <= reg_req.wdata[`MDR_TAKEOVER_BIT];
      speed_value_ff <= reg_req.wdata[`MDR_SPEED_MSB:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlock_key_ff <= `MDR_UNLOCK_KEY_RST;
    end else if (reg_req.wr && hit(reg_req.addr, `MDR_OFS_UNLOCK_KEY)) begin
      unlock_key_ff <= reg_req.wdata;
    end
  end

  // ========================================================================
  // customer space gate
  // exact key match
  assign key_ok = unlock_key_ff == `MDR_CUSTOMER_KEY;
  assign nvm_customer_grant = key_ok
                           && nvm_access_addr >= `MDR_CUST_NVM_FIRST
                           && nvm_access_addr <= `MDR_CUST_NVM_LAST;

  // ========================================================================
  // read decode
  always_comb begin
    nxt_rdata = 16'h0000;
    if (hit(reg_req.addr, `MDR_OFS_ANALOG_SPEED)) begin
      nxt_rdata[`MDR_ANALOG_MSB:0] = analog_speed_code;
    end else if (hit(reg_req.addr, `MDR_OFS_PART_IDENTITY)) begin
      nxt_rdata = {DIE_IDENTIFIER, SILICON_REVISION_CODE};
    end else if (reg_req.addr >= `MDR_OFS_UNUSED_FIRST
              && reg_req.addr <= `MDR_OFS_UNUSED_LAST) begin
      nxt_rdata = 16'h0000;
    end else if (hit(reg_req.addr, `MDR_OFS_SPEED_COMMAND)) begin
      nxt_rdata[`MDR_TAKEOVER_BIT]  = takeover_ff;
      nxt_rdata[`MDR_SPEED_MSB:0]   = speed_value_ff;
    end else if (hit(reg_req.addr, `MDR_OFS_UNLOCK_KEY)) begin
      nxt_rdata = unlock_key_ff;
    end else if (hit(reg_req.addr, `MDR_OFS_NVM_READY)) begin
      nxt_rdata[`MDR_NVM_READY_BIT] = nvm_ready_flag;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req.rd;
      if (reg_req.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ========================================================================
  // speed source
  mdr_speed_select u_speed_select (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .host_speed_takeover (takeover_ff),
    .host_speed_value    (speed_value_ff),
    .pwm_mode            (pwm_mode),
    .analog_cmd          (analog_speed_code[9:1]),
    .pwm_cmd             (pwm_cmd),
    .motor_speed_cmd     (motor_speed_cmd),
    .speed_src           (speed_src)
  );

  // ========================================================================
  // checks
  chk_analog_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_ANALOG_SPEED
    |=> reg_rvalid && reg_rdata == {6'h00, $past(analog_speed_code)})
    else $error("analog code readback wrong");

  chk_die_id: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_PART_IDENTITY
    |=> reg_rdata[15:8] == DIE_IDENTIFIER)
    else $error("die identifier wrong");

  chk_revision_code: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_PART_IDENTITY
    |=> reg_rdata[7:0] == SILICON_REVISION_CODE)
    else $error("revision code wrong");

  chk_unused_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr >= 8'h09 && reg_req.addr <= 8'h2f
    |=> reg_rdata == 16'h0000)
    else $error("unused address read nonzero");

  chk_speed_reset: assert property (
    @(posedge ref_clk)
    $fell(sys_rst) |-> !takeover_ff && speed_value_ff == 9'h000)
    else $error("speed command not zero after reset");

  chk_speed_write: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.wr && reg_req.addr == `MDR_OFS_SPEED_COMMAND
    ##1 !reg_req.wr
    ##1 reg_req.rd && reg_req.addr == `MDR_OFS_SPEED_COMMAND && !reg_req.wr
    |=> reg_rdata == ($past(reg_req.wdata, 3) & 16'h81ff))
    else $error("speed command readback wrong");

  chk_key_store: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.wr && reg_req.addr == `MDR_OFS_UNLOCK_KEY
    |=> unlock_key_ff == $past(reg_req.wdata))
    else $error("unlock key not stored");

  chk_grant_key: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    nvm_customer_grant |-> unlock_key_ff == 16'hc0de
    && nvm_access_addr >= 8'h90 && nvm_access_addr <= 8'h96)
    else $error("customer grant without key");

  chk_ready_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_NVM_READY
    |=> reg_rdata == {15'h0000, $past(nvm_ready_flag)})
    else $error("nvm ready readback wrong");

  chk_takeover_src: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    takeover_ff ##1 takeover_ff |-> speed_src == MDR_SRC_HOST)
    else $error("takeover not reflected in source");

  chk_grant_open: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    unlock_key_ff == 16'hc0de && nvm_access_addr >= 8'h90 && nvm_access_addr <= 8'h96
    |-> nvm_customer_grant)
    else $error("customer grant missing with key");

  chk_speed_store: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.wr && reg_req.addr == `MDR_OFS_SPEED_COMMAND
    |=> takeover_ff == $past(reg_req.wdata[15])
        && speed_value_ff == $past(reg_req.wdata[8:0]))
    else $error("speed command not stored");

  chk_reserved_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_SPEED_COMMAND
    |=> reg_rdata[14:9] == 6'h00)
    else $error("reserved speed bits nonzero");

  chk_key_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_req.rd && reg_req.addr == `MDR_OFS_UNLOCK_KEY
    |=> reg_rvalid && reg_rdata == $past(unlock_key_ff))
    else $error("unlock key readback wrong");

  chk_read_answer: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    reg_rvalid == $past(reg_req.rd))
    else $error("read answer not one cycle after strobe");

  cov_takeover:  cover property (@(posedge ref_clk) takeover_ff ##1 !takeover_ff);
  cov_grant:     cover property (@(posedge ref_clk) nvm_customer_grant);
  cov_id_read:   cover property (@(posedge ref_clk) reg_rvalid && reg_rdata != 16'h0000);
  cov_pwm_src:   cover property (@(posedge ref_clk) speed_src == MDR_SRC_PWM);
  cov_unused_rd: cover property (@(posedge ref_clk) reg_req.rd && reg_req.addr == 8'h2f);
endmodule

// ### sim/mdr_host_model.sv
// Purpose: host side of the register port
// Assumes: requests launched at the falling edge, one idle cycle between them
// Notes: an idle bus shows inverted last address and data, with both strobes low
module mdr_host_model
  import mdr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output mdr_req_s         reg_req,
  output mdr_addr_t        nvm_access_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic      ready_seen;
  mdr_addr_t last_addr;

  initial begin
    reg_req = '0;
    nvm_access_addr = 8'h00;
    ready_seen = 1'b0;
    last_addr = 8'h00;
  end

  // ======================================================================
  // one register access, strobe held for one edge
  task automatic access(input logic rd, input logic wr, input mdr_addr_t a, input mdr_word_t d);
    @(negedge ref_clk);
    reg_req = '{rd, wr, a, d};
    last_addr = a;
    @(negedge ref_clk);
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask

  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1 && last_addr == 8'h32) begin
      ready_seen = reg_rdata[0];
    end
  end

  task automatic nvm_attempt(input mdr_addr_t a);
    @(negedge ref_clk);
    if (ready_seen) begin
      nvm_access_addr = a;
    end
  endtask
endmodule

// ### sim/testbench.sv
// Purpose: self-checking bench of the host register slice
// Assumes: reads answer one cycle after the strobe
// Notes: expected read data queued by the driver
module testbench;
  import mdr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] DIE = 8'h5a; // arbitrary value
  localparam logic [7:0] REV = 8'h03; // arbitrary value
  logic           ref_clk = 1'b0;
  logic           sys_rst = 1'b1;
  mdr_req_s       reg_req;
  logic [15:0]    reg_rdata;
  logic           reg_rvalid;
  logic [9:0]     analog_speed_code = 10'h000;
  logic           pwm_mode = 1'b0;
  logic [8:0]     pwm_cmd = 9'h000;
  logic           nvm_ready_flag = 1'b0;
  mdr_addr_t      nvm_access_addr;
  logic           nvm_customer_grant;
  logic [8:0]     motor_speed_cmd;
  mdr_speed_src_e speed_src;
  int             errors = 0;
  int             checked = 0;
  int             cycles = 0;
  mdr_word_t      expq[$];
  mdr_addr_t      a;
  logic [9:0]     code;
  mdr_addr_t      naddr[4] = '{8'h8f, 8'h90, 8'h96, 8'h97};
  logic           ngrant[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  always #12.5 ref_clk = ~ref_clk;

  mdr_host_regs #(.DIE_IDENTIFIER(DIE), .SILICON_REVISION_CODE(REV)) i_mdr_host_regs (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .analog_speed_code(analog_speed_code), .pwm_mode(pwm_mode),
    .pwm_cmd(pwm_cmd), .nvm_ready_flag(nvm_ready_flag), .nvm_access_addr(nvm_access_addr),
    .nvm_customer_grant(nvm_customer_grant), .motor_speed_cmd(motor_speed_cmd),
    .speed_src(speed_src));

  mdr_host_model i_mdr_host_model (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_req(reg_req),
    .nvm_access_addr(nvm_access_addr));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input mdr_addr_t ad, input mdr_word_t e);
    expq.push_back(e);
    i_mdr_host_model.access(1'b1, 1'b0, ad, 16'h0000);
  endtask

  task automatic wr(input mdr_addr_t ad, input mdr_word_t d);
    i_mdr_host_model.access(1'b0, 1'b1, ad, d);
  endtask

  task automatic wrap_up();
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ======================================================================
  // read answers against queued notes
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      check(16'(expq.size() > 0), 16'h0001);
      if (expq.size() > 0) begin
        check(reg_rdata, expq.pop_front());
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(71));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(8'h30, 16'h0000);
    rd(8'h31, 16'h0000);
    rd(8'h32, 16'h0000);
    rd(8'h08, {DIE, REV});
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h09 : (i == 1) ? 8'h2f : 8'h09 + 8'($urandom_range(38));
      wr(a, 16'hffff);
      rd(a, 16'h0000);
    end
    wr(8'h08, 16'h0000);
    rd(8'h08, {DIE, REV});
    code = 10'($urandom());
    analog_speed_code = code;
    rd(8'h07, {6'h00, code});
    check(16'(motor_speed_cmd), 16'(code[9:1]));
    check(16'(speed_src), 16'(MDR_SRC_ANALOG));
    wr(8'h30, 16'hffff);
    rd(8'h30, 16'h81ff);
    check(16'(motor_speed_cmd), 16'h01ff);
    check(16'(speed_src), 16'(MDR_SRC_HOST));
    pwm_mode = 1'b1;
    pwm_cmd = 9'($urandom());
    wr(8'h30, 16'h0005);
    rd(8'h30, 16'h0005);
    check(16'(motor_speed_cmd), 16'(pwm_cmd));
    check(16'(speed_src), 16'(MDR_SRC_PWM));
    wr(8'h31, 16'hc0de);
    nvm_ready_flag = 1'b1;
    rd(8'h32, 16'h0001);
    rd(8'h31, 16'hc0de);
    for (int i = 0; i < 4; i++) begin
      i_mdr_host_model.nvm_attempt(naddr[i]);
      #1 check(16'(nvm_customer_grant), 16'(ngrant[i]));
    end
    wr(8'h31, 16'hc0df);
    i_mdr_host_model.nvm_attempt(8'h90);
    #1 check(16'(nvm_customer_grant), 16'h0000);
    wr(8'h31, 16'hc0de);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(16'(nvm_customer_grant), 16'h0000);
    rd(8'h30, 16'h0000);
    rd(8'h31, 16'h0000);
    repeat (3) @(negedge ref_clk);
    check(16'(expq.size()), 16'h0000);
    wrap_up();
  end
endmodule
